// ===== hw/lsca_pkg.sv
// Package with register map, field layout and shared types of the load adapter
package lsca_pkg;
   // Register byte offsets (word aligned)
   localparam logic [5:0] LSCA_OFS_CTRL = 6'h00;
   localparam logic [5:0] LSCA_OFS_STALL = 6'h04;
   localparam logic [5:0] LSCA_OFS_VEL = 6'h08;
   localparam logic [5:0] LSCA_OFS_SWITCH = 6'h0C;
   localparam logic [5:0] LSCA_OFS_RESULT = 6'h10;
   localparam logic [5:0] LSCA_OFS_READINGS = 6'h14;
   localparam logic [5:0] LSCA_OFS_IRQ_STS = 6'h18;
   localparam logic [5:0] LSCA_OFS_IRQ_MASK = 6'h1C;
   localparam logic [5:0] LSCA_OFS_PHASE = 6'h20;
   // Control word field positions
   localparam int LSCA_B_FILT = 0;
   localparam int LSCA_B_ANGLE = 1;
   localparam int LSCA_B_MINCUR = 2;
   localparam int LSCA_F_INC = 4;
   localparam int LSCA_F_DEC = 6;
   localparam int LSCA_F_LOWER = 8;
   localparam int LSCA_F_UPPER = 12;
   localparam int LSCA_F_RUN = 16;
   localparam int LSCA_F_CS = 16;
   // Writable bits of each register
   localparam logic [31:0] LSCA_WM_CTRL = 32'h001F_FFF7;
   localparam logic [31:0] LSCA_WM_STALL = 32'h0000_00FF;
   localparam logic [31:0] LSCA_WM_VEL = 32'h000F_FFFF;
   localparam logic [31:0] LSCA_WM_MASK = 32'h0000_0007;
   // Values after reset
   localparam logic [31:0] LSCA_RST_CTRL = 32'h001F_0000;
   localparam logic [31:0] LSCA_RST_STALL = 32'h0000_0000;
   localparam logic [31:0] LSCA_RST_VEL = 32'h0000_0000;
   localparam logic [31:0] LSCA_RST_SWITCH = 32'h0000_0000;
   localparam logic [31:0] LSCA_RST_MASK = 32'h0000_0000;
   // Interrupt status bit positions
   localparam int LSCA_I_STALL = 0;
   localparam int LSCA_I_UPDATE = 1;
   localparam int LSCA_I_CURRENT = 2;
   // Load value scaling
   localparam logic [8:0] LSCA_LOAD_FULL = 9'h1FE;
   localparam int LSCA_LAG_SHIFT = 1;
   localparam int LSCA_THR_SHIFT = 5;
   // Zero crossing event group, one-cycle pulses
   typedef struct packed {
      logic b_rise;
      logic b_fall;
      logic a_rise;
      logic a_fall;
   } lsca_zero_t;
   // Avalon-MM slave request group
   typedef struct packed {
      logic [5:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } lsca_avs_req_t;
endpackage

// ===== hw/lsca_core.sv
// Load evaluation, stall pulse and load-adaptive current scaling with register slave
//
// Functional notes
// - Unfiltered: one fresh reading per fullstep
// - Filtered: four readings, result is their average
// - Readings captured at coil A/B zero crossings
// - Average recomputed every fullstep, quarter weight each
// - Phase lag offset stored and removed on switching
// - Pulse stall output when load below threshold
// - Stall pulse only in voltage mode velocity window
// - Adapter uses load of the active chopper
// - Four-bit lower setting, zero disables adaptation
// - Below lower setting times 32 raises current
// - Enough samples above upper threshold lower current
// - Adapter compares a ten-bit load value
// - Stall level is twice the programmed threshold
// - Increment width 1, 2, 4 or 8
// - Samples per decrement 32, 8, 2 or 1
// - Minimum current half or quarter of run
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ns
module lsca_core #(
   parameter int VEL_W = 20 // Width of step period and thresholds
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Avalon-MM slave
   input wire lsca_pkg::lsca_avs_req_t avs_req_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Motor measurement inputs, same clock
   input wire lsca_pkg::lsca_zero_t zero_cross_in,
   input wire logic [7:0] vmode_sample_in,
   input wire logic vmode_active_in,
   input wire logic [9:0] cmode_load_value_in,
   input wire logic cmode_sample_valid_in,
   input wire logic [VEL_W-1:0] measured_step_period_in,
   // Results toward the driver
   output logic diag_stall_out,
   output logic [4:0] current_scale_out,
   output logic [8:0] vmode_load_value_out,
   output logic [7:0] phase_offset_out,
   // Interrupt
   output logic irq_out
);
   import lsca_pkg::*;

   // Refuse widths the register slave cannot hold, at elaboration
   if (VEL_W < 1 || VEL_W > 20) begin : g_vel_w_bad
      $error("VEL_W must be 1 to 20");
   end

   // All state of the block
   typedef struct packed {
      logic [31:0] ctrl;        // Control word
      logic [31:0] stall;       // Stall threshold word
      logic [31:0] vel;         // Adapt velocity threshold
      logic [31:0] sw;          // Chopper switch threshold
      logic [31:0] mask;        // Interrupt mask
      logic [2:0] sts;          // Sticky interrupt status
      logic [3:0][7:0] rd;      // Individual readings
      logic [8:0] result;       // Voltage-mode load value
      logic [4:0] cs;           // Adapted current scale
      logic [4:0] dn_cnt;       // Samples toward one decrement
      logic [7:0] phase;        // Stored phase offset
      logic cmode_q;            // Current chopper seen last cycle
      logic stall_p;            // Stall pulse register
      logic ack;                // Bus answer cycle
      logic [31:0] rdata;       // Read data register
   } lsca_state_t;

   lsca_state_t st;
   lsca_state_t next_st;

   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] lsca_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be, input logic [31:0] wm);
      logic [31:0] lanes;
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      lsca_merge = ((old & ~(lanes & wm)) | (wd & lanes & wm));
   endfunction

   // Samples needed for one decrement
   function automatic logic [4:0] lsca_dn_limit(input logic [1:0] sel);
      case (sel)
         2'h0: lsca_dn_limit = 5'h1F; // 32 samples
         2'h1: lsca_dn_limit = 5'h07; // 8 samples
         2'h2: lsca_dn_limit = 5'h01; // 2 samples
         default: lsca_dn_limit = 5'h00; // 1 sample
      endcase
   endfunction

   // Decoded settings
   logic filt_en;
   logic angle_en;
   logic min_quarter;
   logic [1:0] inc_sel;
   logic [1:0] dec_sel;
   logic [3:0] lower_set;
   logic [3:0] upper_set;
   logic [4:0] run_cur;
   logic [4:0] min_cur;
   logic [10:0] lower_thr;
   logic [10:0] upper_thr;
   logic fullstep;
   logic in_window;
   logic stall_en;
   logic bus_req;
   logic bus_take;

   // Field extraction and thresholds
   always_comb begin
      filt_en = st.ctrl[LSCA_B_FILT];
      angle_en = st.ctrl[LSCA_B_ANGLE];
      min_quarter = st.ctrl[LSCA_B_MINCUR];
      inc_sel = st.ctrl[LSCA_F_INC +: 2];
      dec_sel = st.ctrl[LSCA_F_DEC +: 2];
      lower_set = st.ctrl[LSCA_F_LOWER +: 4];
      upper_set = st.ctrl[LSCA_F_UPPER +: 4];
      run_cur = st.ctrl[LSCA_F_RUN +: 5];
      // Half or quarter of the run current
      min_cur = min_quarter ? (run_cur >> 2) : (run_cur >> 1);
      lower_thr = {7'h00, lower_set} << LSCA_THR_SHIFT;
      upper_thr = ({7'h00, lower_set} + {7'h00, upper_set} + 11'h001) << LSCA_THR_SHIFT;
      fullstep = |zero_cross_in;
      // Velocity window between switch threshold and adapt threshold
      in_window = (measured_step_period_in <= st.vel[VEL_W-1:0]) &&
                  (measured_step_period_in > st.sw[VEL_W-1:0]);
      stall_en = vmode_active_in && in_window;
      bus_req = avs_req_in.read || avs_req_in.write;
      bus_take = bus_req && st.ack;
   end

   // Next state of the whole block
   always_comb begin
      logic [9:0] sum;
      logic [9:0] samp;
      logic samp_v;
      logic [5:0] raised;
      logic [4:0] cs_n;
      logic [2:0] ev;
      sum = 10'h000;
      samp = 10'h000;
      samp_v = 1'b0;
      raised = 6'h00;
      cs_n = st.cs;
      ev = 3'h0;
      next_st = st;
      next_st.stall_p = 1'b0;

      // Capture readings at the zero crossings
      if (fullstep) begin
         if (filt_en) begin
            for (int i = 0; i < 4; i++) begin
               if (zero_cross_in[i]) begin
                  next_st.rd[i] = vmode_sample_in;
               end
            end
            // Average of the four most recent readings
            sum = 10'(next_st.rd[0]) + 10'(next_st.rd[1]) + 10'(next_st.rd[2]) +
                  10'(next_st.rd[3]);
            next_st.result = sum[9:1];
         end else begin
            // Single reading stands until the next fullstep
            next_st.rd[0] = vmode_sample_in;
            next_st.result = {vmode_sample_in, 1'b0};
         end
         ev[LSCA_I_UPDATE] = 1'b1;
         // Twice the threshold is the stall level
         if (stall_en && (next_st.result < {st.stall[7:0], 1'b0})) begin
            next_st.stall_p = 1'b1;
            ev[LSCA_I_STALL] = 1'b1;
         end
      end

      // Load source follows the running chopper
      if (vmode_active_in) begin
         samp = {1'b0, next_st.result};
         samp_v = fullstep;
      end else begin
         samp = cmode_load_value_in;
         samp_v = cmode_sample_valid_in;
      end

      // Load-adaptive current control
      if ((lower_set == 4'h0) || !in_window) begin
         cs_n = run_cur;
         next_st.dn_cnt = 5'h00;
      end else if (samp_v) begin
         if ({1'b0, samp} < lower_thr) begin
            // Raise by 1, 2, 4 or 8
            raised = {1'b0, st.cs} + (6'h01 << inc_sel);
            cs_n = (raised > {1'b0, run_cur}) ? run_cur : raised[4:0];
            next_st.dn_cnt = 5'h00;
         end else if ({1'b0, samp} >= upper_thr) begin
            if (st.dn_cnt >= lsca_dn_limit(dec_sel)) begin
               cs_n = (st.cs > min_cur) ? (st.cs - 5'h01) : min_cur;
               next_st.dn_cnt = 5'h00;
            end else begin
               next_st.dn_cnt = st.dn_cnt + 5'h01;
            end
         end
      end
      // Keep the scale within limits after setting changes
      if (cs_n > run_cur) begin
         cs_n = run_cur;
      end else if (cs_n < min_cur) begin
         cs_n = min_cur;
      end
      ev[LSCA_I_CURRENT] = (cs_n != st.cs);
      next_st.cs = cs_n;

      // Phase lag offset across chopper switches
      next_st.cmode_q = !vmode_active_in;
      if (!vmode_active_in && !st.cmode_q && angle_en) begin
         next_st.phase = 8'((LSCA_LOAD_FULL - st.result) >> LSCA_LAG_SHIFT);
      end else if (vmode_active_in && st.cmode_q) begin
         next_st.phase = 8'h00;
      end

      // Bus slave: answer in the second cycle of a request
      next_st.ack = bus_req && !st.ack;
      if (bus_req && !st.ack && avs_req_in.read) begin
         case (avs_req_in.address)
            LSCA_OFS_CTRL: next_st.rdata = st.ctrl;
            LSCA_OFS_STALL: next_st.rdata = st.stall;
            LSCA_OFS_VEL: next_st.rdata = st.vel;
            LSCA_OFS_SWITCH: next_st.rdata = st.sw;
            LSCA_OFS_RESULT: next_st.rdata = {11'h000, st.cs, 7'h00, st.result};
            LSCA_OFS_READINGS: next_st.rdata = st.rd;
            LSCA_OFS_IRQ_STS: next_st.rdata = {29'h0000_0000, st.sts};
            LSCA_OFS_IRQ_MASK: next_st.rdata = st.mask;
            LSCA_OFS_PHASE: next_st.rdata = {24'h00_0000, st.phase};
            default: next_st.rdata = 32'h0000_0000; // Unmapped reads zero
         endcase
      end
      // Writes take effect in the answer cycle
      if (bus_take && avs_req_in.write) begin
         case (avs_req_in.address)
            LSCA_OFS_CTRL: begin
               next_st.ctrl = lsca_merge(st.ctrl, avs_req_in.writedata,
                                         avs_req_in.byteenable, LSCA_WM_CTRL);
            end
            LSCA_OFS_STALL: begin
               next_st.stall = lsca_merge(st.stall, avs_req_in.writedata,
                                          avs_req_in.byteenable, LSCA_WM_STALL);
            end
            LSCA_OFS_VEL: begin
               next_st.vel = lsca_merge(st.vel, avs_req_in.writedata,
                                        avs_req_in.byteenable, LSCA_WM_VEL);
            end
            LSCA_OFS_SWITCH: begin
               next_st.sw = lsca_merge(st.sw, avs_req_in.writedata,
                                       avs_req_in.byteenable, LSCA_WM_VEL);
            end
            LSCA_OFS_IRQ_MASK: begin
               next_st.mask = lsca_merge(st.mask, avs_req_in.writedata,
                                         avs_req_in.byteenable, LSCA_WM_MASK);
            end
            default: begin
               next_st.mask = st.mask; // Other writes ignored
            end
         endcase
      end
      // Read clears only the reported bits, a new event wins
      if (bus_take && avs_req_in.read && (avs_req_in.address == LSCA_OFS_IRQ_STS)) begin
         // Bits raised during the wait cycle were not reported yet
         next_st.sts = (st.sts & ~st.rdata[2:0]) | ev;
      end else begin
         next_st.sts = st.sts | ev;
      end
   end

   // State register
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '0;
         st.ctrl <= LSCA_RST_CTRL;
         st.stall <= LSCA_RST_STALL;
         st.vel <= LSCA_RST_VEL;
         st.sw <= LSCA_RST_SWITCH;
         st.mask <= LSCA_RST_MASK;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   always_comb begin
      avs_readdata_out = st.rdata;
      avs_waitrequest_out = bus_req && !st.ack;
      diag_stall_out = st.stall_p;
      current_scale_out = st.cs;
      vmode_load_value_out = st.result;
      phase_offset_out = st.phase;
      irq_out = |(st.sts & st.mask[2:0]);
   end
endmodule

// ===== tb/lsca_chk.sv
// Port level checks of the load adapter core
`timescale 1ns/1ns
module lsca_chk (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Watched inputs
   input wire lsca_pkg::lsca_avs_req_t avs_req_in,
   input wire lsca_pkg::lsca_zero_t zero_cross_in,
   input wire logic vmode_active_in,
   // Watched outputs
   input wire logic avs_waitrequest_out,
   input wire logic diag_stall_out,
   input wire logic [8:0] vmode_load_value_out,
   input wire logic [7:0] phase_offset_out,
   input wire logic irq_out
);
   import lsca_pkg::*;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   stall_pulse_a: assert property (diag_stall_out && !(|zero_cross_in) |=> !diag_stall_out)
      else $error("stall pulse longer than one cycle");
   stall_cause_a: assert property (diag_stall_out |-> $past(|zero_cross_in))
      else $error("stall pulse without a fullstep");
   stall_mode_a: assert property (diag_stall_out |-> $past(vmode_active_in))
      else $error("stall pulse outside voltage mode");
   load_hold_a: assert property ($changed(vmode_load_value_out) |-> $past(|zero_cross_in))
      else $error("load value changed between fullsteps");
   load_range_a: assert property (vmode_load_value_out <= 9'h1FE)
      else $error("load value above full scale");
   phase_vmode_a: assert property (vmode_active_in ##1 vmode_active_in |=>
      phase_offset_out == 8'h00) else $error("phase offset kept in voltage mode");
   phase_hold_a: assert property (!vmode_active_in [*3] |=> $stable(phase_offset_out))
      else $error("phase offset moved in current mode");
   bus_wait_a: assert property ($rose(avs_req_in.read | avs_req_in.write) |->
      avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("wait cycle count wrong");
   // Main scenarios reached
   cover property (diag_stall_out);
   cover property (irq_out);
   cover property (phase_offset_out != 8'h00);
endmodule
bind lsca_core lsca_chk u_lsca_chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
   .avs_req_in(avs_req_in), .zero_cross_in(zero_cross_in), .vmode_active_in(vmode_active_in),
   .avs_waitrequest_out(avs_waitrequest_out), .diag_stall_out(diag_stall_out),
   .vmode_load_value_out(vmode_load_value_out), .phase_offset_out(phase_offset_out),
   .irq_out(irq_out));

// ===== tb/lsca_ctrl_model.sv
// Motion controller that halts the motor on the first stall pulse
`timescale 1ns/1ns
module lsca_ctrl_model (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Stall pulse from the driver
   input wire logic diag_stall_in,
   // Motor run permission
   output logic motor_run_out
);
   // One pulse is enough, no waiting for repeats
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         motor_run_out <= 1'b1;
      end else if (diag_stall_in) begin
         motor_run_out <= 1'b0;
      end
   end
endmodule

// ===== tb/lsca_core_bench.sv
// Self-checking bench of the load adapter core
`timescale 1ns/1ns
module lsca_core_bench;
   import lsca_pkg::*;
   logic clk, rst_b, wreq, stall, irq, run, cv, va;
   lsca_avs_req_t req;
   lsca_zero_t zc;
   logic [31:0] rdata, q;
   logic [7:0] vs, ph;
   logic [9:0] cl;
   logic [19:0] per;
   logic [4:0] scale;
   logic [8:0] val;
   int failures, checked, seed, np, m, e, n;
   int rd[4];
   int pv[5] = '{50, 101, 10, 100, 11};
   int nd[4] = '{32, 8, 2, 1};
   lsca_core u_lsca_core (.clock_in(clk), .rst_b_in(rst_b), .avs_req_in(req),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .zero_cross_in(zc),
      .vmode_sample_in(vs), .vmode_active_in(va), .cmode_load_value_in(cl),
      .cmode_sample_valid_in(cv), .measured_step_period_in(per), .diag_stall_out(stall),
      .current_scale_out(scale), .vmode_load_value_out(val), .phase_offset_out(ph),
      .irq_out(irq));
   lsca_ctrl_model u_lsca_ctrl_model (.clock_in(clk), .rst_b_in(rst_b),
      .diag_stall_in(stall), .motor_run_out(run));
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Stall pulse count
   always @(posedge clk) begin
      if (stall === 1'b1) np <= np + 1;
   end
   // Outputs read after it still show the state sampled at this edge
   task automatic tick();
      @(posedge clk);
   endtask
   task automatic finish_test();
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   // Avalon cycle held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int k;
      req <= '{a, !wr, wr, 4'hF, d};
      k = 0;
      do begin
         tick();
         k++;
      end while (wreq !== 1'b0 && k < 20);
      if (k >= 20) begin
         failures++;
         finish_test();
      end
      q = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      tick();
   endtask
   task automatic reset();
      rst_b <= 1'b0;
      repeat (10) tick();
      rst_b <= 1'b1;
      repeat (2) tick();
   endtask
   task automatic cfg(input logic [31:0] ctrl);
      bus(1, LSCA_OFS_VEL, 100);
      bus(1, LSCA_OFS_SWITCH, 10);
      bus(1, LSCA_OFS_CTRL, ctrl);
   endtask
   // One fullstep at zero crossing kind k
   task automatic step(input int k, input logic [7:0] s);
      zc <= lsca_zero_t'(4'h1 << k);
      vs <= s;
      tick();
      zc <= lsca_zero_t'(4'h0);
      repeat (3) tick();
   endtask
   // Load sample, high or low, voltage or current path
   task automatic samp(input logic hi, input logic cm);
      if (cm) begin
         va <= 1'b0;
         cl <= hi ? 10'h300 : 10'h010;
         cv <= 1'b1;
         tick();
         cv <= 1'b0;
         repeat (3) tick();
         va <= 1'b1;
      end else begin
         step(0, hi ? 8'd100 : 8'd10);
      end
   endtask
   initial begin
      seed = 32'h83D89E60;
      rst_b = 1'b0;
      req = '0;
      zc = '0;
      vs = 8'h00;
      va = 1'b1;
      cl = 10'h000;
      cv = 1'b0;
      per = 20'd50;
      reset();
      chk("scale", 31, scale);
      bus(0, LSCA_OFS_CTRL, 0);
      chk("ctrl", LSCA_RST_CTRL, q);
      bus(0, 6'h3C, 0);
      chk("unmapped", 0, q);
      cfg(32'h001C_0000);
      m = 510;
      for (int i = 0; i < 8; i++) begin
         e = ($random(seed) & 255) | 1;
         step(i % 4, 8'(e));
         chk("load", e * 2, val);
         if (e * 2 < m) m = e * 2;
      end
      bus(0, LSCA_OFS_READINGS, 0);
      chk("reading", e, q[7:0]);
      bus(1, LSCA_OFS_STALL, m / 2);
      n = np;
      step(2, 8'(m / 2));
      chk("level", n, np);
      step(3, 8'(m / 2 - 1));
      chk("stall", n + 1, np);
      chk("halted", 0, run);
      chk("irq masked", 0, irq);
      bus(1, LSCA_OFS_IRQ_MASK, 1);
      chk("irq", 1, irq);
      bus(0, LSCA_OFS_IRQ_STS, 0);
      chk("status", 1, q[0]);
      tick();
      chk("irq clear", 0, irq);
      // Velocity window and chopper mode gate the pulse
      for (int i = 0; i < 5; i++) begin
         va <= (i != 0);
         per <= 20'(pv[i]);
         tick();
         n = np;
         step(0, 8'h00);
         chk("window", n + (i > 2), np);
      end
      va <= 1'b1;
      per <= 20'd50;
      bus(1, LSCA_OFS_CTRL, 32'h001C_0001);
      for (int i = 0; i < 8; i++) begin
         rd[i % 4] = $random(seed) & 255;
         step(i % 4, 8'(rd[i % 4]));
         if (i > 2) chk("avg", (rd[0] + rd[1] + rd[2] + rd[3]) / 2, val);
      end
      bus(0, LSCA_OFS_READINGS, 0);
      chk("readings", {8'(rd[3]), 8'(rd[2]), 8'(rd[1]), 8'(rd[0])}, q);
      bus(1, LSCA_OFS_CTRL, 32'h001C_0002);
      step(0, 8'd60);
      bus(0, LSCA_OFS_RESULT, 0);
      chk("result", 32'h001C_0078, q);
      va <= 1'b0;
      repeat (3) tick();
      chk("phase", 195, ph);
      va <= 1'b1;
      repeat (3) tick();
      chk("phase back", 0, ph);
      // Adaptation per step and count setting, fresh reset each
      for (int c = 0; c < 4; c++) begin
         reset();
         cfg(32'h001C_0000);
         bus(1, LSCA_OFS_CTRL, 32'h001C_1200 | c << 4 | c << 6 | (c & 1) << 2);
         m = (c & 1) ? 7 : 14;
         e = 28;
         n = 0;
         for (int i = 0; i < nd[c] * (28 - m) + 2; i++) begin
            samp(1, i % 2);
            n++;
            if (n == nd[c]) begin
               n = 0;
               if (e > m) e--;
            end
            chk("down", e, scale);
         end
         for (int i = 0; i < 5; i++) begin
            samp(0, i % 2);
            e = (e + (1 << c) > 28) ? 28 : e + (1 << c);
            chk("up", e, scale);
         end
         bus(1, LSCA_OFS_CTRL, 32'h001C_0000);
         tick();
         chk("off", 28, scale);
      end
      finish_test();
   end
endmodule
